//--- logic/drcm_pkg.sv
// Constants, widths and types shared by the data-rate and clock monitor.
// Assumes the system clock is 40 MHz and rates are carried in whole hertz.
package drcm_pkg;

    // Clock and width figures
    localparam longint SYS_CLK_HZ     = 40_000_000;
    localparam int     RATE_W         = 28;
    localparam int     CNT_W          = 24;
    localparam int     DLY_W          = 14;
    localparam int     LEN_W          = RATE_W + DLY_W;
    localparam int     NUM_CLK        = 4;

    // Connector clock indices
    localparam int     CH_W_RX        = 0;
    localparam int     CH_W_TX        = 1;
    localparam int     CH_E_TX        = 2;
    localparam int     CH_E_RX        = 3;

    // Synthesizer range, in 1 Hz steps
    localparam logic [RATE_W-1:0] RATE_MIN_HZ  = 28'd100;
    localparam logic [RATE_W-1:0] RATE_MAX_HZ  = 28'd52_000_000;
    localparam logic [RATE_W-1:0] RATE_SYNC_HZ = RATE_MIN_HZ;

    // Measurement resolution
    localparam logic [RATE_W-1:0] RES_LO_HZ    = 28'd20;
    localparam logic [RATE_W-1:0] RES_HI_HZ    = 28'd200;
    localparam logic [RATE_W-1:0] RES_SPLIT_HZ = 28'd5_000_000;
    localparam longint GATE_FAST_CYC = SYS_CLK_HZ / 200;
    localparam int     GATE_RATIO    = 10;

    // Panel timing
    localparam longint PARAM_TIMEOUT_S   = 30;
    localparam longint PARAM_TIMEOUT_CYC = PARAM_TIMEOUT_S * SYS_CLK_HZ;
    localparam longint BLINK_HALF_MS     = 250;
    localparam longint BLINK_HALF_CYC    = BLINK_HALF_MS * SYS_CLK_HZ / 1000;

    // Delay length: milliseconds times hertz over this gives bits
    localparam logic [10:0] MS_PER_S = 11'd1000;

    typedef enum logic [1:0] {
        DRCM_TIME_LOOP,
        DRCM_TIME_INTERNAL,
        DRCM_TIME_EXTERNAL
    } drcm_timing_t;

    typedef enum logic [1:0] {
        DRCM_SRC_LOOP,
        DRCM_SRC_OSC,
        DRCM_SRC_SYNTH,
        DRCM_SRC_EXT
    } drcm_src_t;

    typedef enum logic [1:0] {
        DRCM_PATH_NORMAL,
        DRCM_PATH_BYPASS,
        DRCM_PATH_OUT_LOOP
    } drcm_path_t;

endpackage

//--- logic/drcm_edge_counter.sv
// Edge counter for one connector clock with a gray-coded crossing.
// Assumes the connector clock may stop; the count then simply holds.
`timescale 1ns/1ps
module drcm_edge_counter (
    // Connector side
    input  wire logic                      i_clk_link,
    // System side
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_reset_n,
    output logic [drcm_pkg::CNT_W-1:0]     o_count
);
    import drcm_pkg::*;

    logic [CNT_W-1:0] link_count;
    logic [CNT_W-1:0] link_gray;
    logic [CNT_W-1:0] sync_a;
    logic [CNT_W-1:0] sync_b;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] bin;

    assign next_count = link_count + 24'h000001;

    // Link domain: binary count and its registered gray image
    always_ff @(posedge i_clk_link or negedge i_reset_n) begin
        if (!i_reset_n) begin
            link_count <= '0;
            link_gray  <= '0;
        end else begin
            link_count <= next_count;
            link_gray  <= next_count ^ (next_count >> 1);
        end
    end

    // Only one bit changes per edge, so the two-stage sample is safe
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= link_gray;
            sync_b <= sync_a;
        end
    end

    always_comb begin
        bin[CNT_W-1] = sync_b[CNT_W-1];
        for (int k = CNT_W - 2; k >= 0; k--) begin
            bin[k] = bin[k+1] ^ sync_b[k];
        end
    end

    assign o_count = bin;

endmodule

//--- logic/drcm_monitor.sv
// Data-rate setting, network clock selection, connector clock monitor,
// delay-length computation and parameter-edit timeout for both channels.
// Assumes the panel controls arrive on the system clock and the four
// connector clocks are free-running or stopped ports of their own.
//
// Summary of operation
// RULE1 - Choosing an interface loads its nominal rate, or 100 Hz for a synchronous one.
// RULE2 - The synthesizer is programmed with any whole-hertz rate from 100 Hz to 52 MHz.
// RULE3 - A fixed interface at its nominal rate uses the oscillator, else the synthesizer.
// RULE4 - All four connector clocks are measured continuously and shown on outputs.
// RULE5 - Measurements resolve to 20 Hz below 5 MHz and to 200 Hz from 5 MHz up.
// RULE6 - A clock that disagrees with the rate setting blinks its own indicator.
// RULE7 - In internal timing a receive connector with no clock counts as a mismatch.
// RULE8 - On request the measured rate of one chosen connector becomes the rate setting.
// RULE9 - The rate setting programs the synthesizer and sizes both delay buffers.
// RULE10 - The network clock comes from the loop, the internal oscillator or the external input.
// RULE11 - Bypass and outward loopback route data around the delay and error generators.
// RULE12 - An edit with no activity for 30 seconds returns to the main display.
// RULE13 - A delay or rate change recomputes and resets the buffers while a fill pattern is sent.
// RULE14 - A mismatch is a difference above one resolution step for that range.
`timescale 1ns/1ps
module drcm_monitor #(
    parameter longint GATE_CYC    = drcm_pkg::GATE_FAST_CYC,
    parameter longint TIMEOUT_CYC = drcm_pkg::PARAM_TIMEOUT_CYC,
    parameter longint BLINK_CYC   = drcm_pkg::BLINK_HALF_CYC
) (
    // System
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_reset_n,
    // Connector clocks
    input  wire logic                          i_clk_w_rx,
    input  wire logic                          i_clk_w_tx,
    input  wire logic                          i_clk_e_tx,
    input  wire logic                          i_clk_e_rx,
    // Interface choice
    input  wire logic                          i_iface_load,
    input  wire logic                          i_iface_fixed,
    input  wire logic [drcm_pkg::RATE_W-1:0]   i_iface_nominal,
    // Rate entry
    input  wire logic                          i_rate_write,
    input  wire logic [drcm_pkg::RATE_W-1:0]   i_rate_value,
    input  wire logic                          i_copy_req,
    input  wire logic [1:0]                    i_copy_sel,
    // Timing and path mode
    input  wire drcm_pkg::drcm_timing_t        i_timing,
    input  wire drcm_pkg::drcm_path_t          i_path_mode,
    // Delay entry
    input  wire logic                          i_delay_write,
    input  wire logic [drcm_pkg::DLY_W-1:0]    i_delay_e_ms,
    input  wire logic [drcm_pkg::DLY_W-1:0]    i_delay_w_ms,
    input  wire logic                          i_fill_ones,
    // Channel data
    input  wire logic                          i_east_line,
    input  wire logic                          i_west_line,
    input  wire logic                          i_east_delayed,
    input  wire logic                          i_west_delayed,
    // Panel
    input  wire logic                          i_panel_activity,
    input  wire logic                          i_panel_change,
    // Rate and clock source
    output logic [drcm_pkg::RATE_W-1:0]        o_rate,
    output logic [drcm_pkg::RATE_W-1:0]        o_synth_freq,
    output drcm_pkg::drcm_src_t                o_net_src,
    // Measurements and indicators
    output logic [drcm_pkg::RATE_W-1:0]        o_meas_w_rx,
    output logic [drcm_pkg::RATE_W-1:0]        o_meas_w_tx,
    output logic [drcm_pkg::RATE_W-1:0]        o_meas_e_tx,
    output logic [drcm_pkg::RATE_W-1:0]        o_meas_e_rx,
    output logic [3:0]                         o_led_blink,
    // Delay buffers and data path
    output logic [drcm_pkg::LEN_W-1:0]         o_len_e,
    output logic [drcm_pkg::LEN_W-1:0]         o_len_w,
    output logic                               o_buf_reset,
    output logic                               o_gen_enable,
    output logic                               o_east_out,
    output logic                               o_west_out,
    // Panel state
    output logic                               o_param_edit
);
    import drcm_pkg::*;

    typedef enum logic { DRCM_ST_MAIN, DRCM_ST_EDIT } drcm_panel_t;

    function automatic logic [RATE_W-1:0] abs_diff(input logic [RATE_W-1:0] a,
                                                  input logic [RATE_W-1:0] b);
        abs_diff = (a > b) ? a - b : b - a;
    endfunction

    // One division step by 1000: shifted-in remainder, then subtract
    function automatic logic [11:0] div_step(input logic [10:0] rem, input logic bit_in);
        logic [11:0] wide;
        wide = {rem, bit_in};
        div_step = (wide >= {1'b0, MS_PER_S}) ? wide - {1'b0, MS_PER_S} : wide;
    endfunction

    // ---------------- Connector clock measurement ----------------
    logic [NUM_CLK-1:0] link_clk;
    logic [CNT_W-1:0]   edge_cnt [NUM_CLK];
    logic [CNT_W-1:0]   snap_fast [NUM_CLK];
    logic [CNT_W-1:0]   snap_slow [NUM_CLK];
    logic [RATE_W-1:0]  meas [NUM_CLK];
    logic [RATE_W-1:0]  fast_hz [NUM_CLK];
    logic [RATE_W-1:0]  slow_hz [NUM_CLK];
    logic [31:0]        gate_cnt;
    logic [3:0]         gate_idx;
    logic               gate_tick;
    logic               slow_tick;

    assign link_clk = {i_clk_e_rx, i_clk_e_tx, i_clk_w_tx, i_clk_w_rx};

    for (genvar g = 0; g < NUM_CLK; g++) begin : g_cnt
        drcm_edge_counter u_cnt (
            .i_clk_link (link_clk[g]),
            .i_clk_sys  (i_clk_sys),
            .i_reset_n  (i_reset_n),
            .o_count    (edge_cnt[g])
        );
        // A 5 ms gate gives 200 Hz steps, ten of them give 20 Hz steps
        assign fast_hz[g] = RATE_W'(32'(CNT_W'(edge_cnt[g] - snap_fast[g])) * 32'(RES_HI_HZ)); // RULE5
        assign slow_hz[g] = RATE_W'(32'(CNT_W'(edge_cnt[g] - snap_slow[g])) * 32'(RES_LO_HZ)); // RULE5
    end

    assign gate_tick = (gate_cnt == 32'(GATE_CYC - 1));
    assign slow_tick = gate_tick && (gate_idx == 4'(GATE_RATIO - 1));

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            gate_cnt <= '0;
            gate_idx <= '0;
        end else begin
            gate_cnt <= gate_tick ? '0 : gate_cnt + 32'h00000001;
            gate_idx <= slow_tick ? '0 : (gate_tick ? gate_idx + 4'h1 : gate_idx);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int c = 0; c < NUM_CLK; c++) begin
                snap_fast[c] <= '0;
                snap_slow[c] <= '0;
                meas[c]      <= '0;
            end
        end else begin
            for (int c = 0; c < NUM_CLK; c++) begin
                if (gate_tick) begin
                    snap_fast[c] <= edge_cnt[c];
                end
                if (slow_tick) begin
                    snap_slow[c] <= edge_cnt[c];
                end
                // Fast clocks refresh every gate; slow ones every tenth
                if (gate_tick && fast_hz[c] >= RES_SPLIT_HZ) begin
                    meas[c] <= fast_hz[c]; // RULE4
                end else if (slow_tick) begin
                    meas[c] <= slow_hz[c]; // RULE4
                end
            end
        end
    end

    assign o_meas_w_rx = meas[CH_W_RX];
    assign o_meas_w_tx = meas[CH_W_TX];
    assign o_meas_e_tx = meas[CH_E_TX];
    assign o_meas_e_rx = meas[CH_E_RX];

    // ---------------- Rate setting and clock source ----------------
    logic [RATE_W-1:0] rate;
    logic [RATE_W-1:0] nominal;
    logic              fixed_iface;
    logic [RATE_W-1:0] next_rate;
    logic              rate_load;

    assign rate_load = i_iface_load || i_copy_req || i_rate_write;
    assign next_rate = i_iface_load ? (i_iface_fixed ? i_iface_nominal : RATE_SYNC_HZ) // RULE1
                     : i_copy_req   ? meas[i_copy_sel]                                   // RULE8
                     : i_rate_write ? i_rate_value : rate;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rate        <= RATE_SYNC_HZ;
            nominal     <= RATE_SYNC_HZ;
            fixed_iface <= 1'b0;
        end else begin
            rate <= next_rate;
            if (i_iface_load) begin
                nominal     <= i_iface_nominal;
                fixed_iface <= i_iface_fixed;
            end
        end
    end

    assign o_rate = rate;
    // Whole-hertz word, clamped to what the synthesizer can make
    assign o_synth_freq = (rate < RATE_MIN_HZ) ? RATE_MIN_HZ
                        : (rate > RATE_MAX_HZ) ? RATE_MAX_HZ : rate; // RULE2 RULE9

    wire use_synth = !fixed_iface || (rate != nominal); // RULE3
    always_comb begin
        case (i_timing) // RULE10
            DRCM_TIME_LOOP:     o_net_src = DRCM_SRC_LOOP;
            DRCM_TIME_INTERNAL: o_net_src = use_synth ? DRCM_SRC_SYNTH : DRCM_SRC_OSC; // RULE3
            DRCM_TIME_EXTERNAL: o_net_src = DRCM_SRC_EXT;
            default:            o_net_src = DRCM_SRC_OSC;
        endcase
    end

    // ---------------- Mismatch indicators ----------------
    logic [NUM_CLK-1:0] mismatch;
    logic [31:0]        blink_cnt;
    logic               blink_phase;

    for (genvar g = 0; g < NUM_CLK; g++) begin : g_mis
        wire [RATE_W-1:0] step = (meas[g] < RES_SPLIT_HZ) ? RES_LO_HZ : RES_HI_HZ;
        wire              is_rx = (g == CH_W_RX) || (g == CH_E_RX);
        // A dead clock is only a fault where this unit expects it to arrive
        assign mismatch[g] = (meas[g] == '0)
                           ? (is_rx && i_timing == DRCM_TIME_INTERNAL) // RULE7
                           : (abs_diff(meas[g], rate) > step);         // RULE14
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            blink_cnt   <= '0;
            blink_phase <= 1'b0;
            o_led_blink <= '0;
        end else begin
            blink_cnt   <= (blink_cnt == 32'(BLINK_CYC - 1)) ? '0 : blink_cnt + 32'h00000001;
            blink_phase <= (blink_cnt == 32'(BLINK_CYC - 1)) ? !blink_phase : blink_phase;
            o_led_blink <= mismatch & {NUM_CLK{blink_phase}}; // RULE6
        end
    end

    // ---------------- Delay buffer length ----------------
    logic [DLY_W-1:0]  dly_e;
    logic [DLY_W-1:0]  dly_w;
    logic [LEN_W-1:0]  dvd_e;
    logic [LEN_W-1:0]  dvd_w;
    logic [10:0]       rem_e;
    logic [10:0]       rem_w;
    logic [5:0]        div_left;
    logic              busy;
    wire  [11:0]       step_e = div_step(rem_e, dvd_e[LEN_W-1]);
    wire  [11:0]       step_w = div_step(rem_w, dvd_w[LEN_W-1]);
    wire               restart = rate_load || i_delay_write;
    wire  [DLY_W-1:0]  next_dly_e = i_delay_write ? i_delay_e_ms : dly_e;
    wire  [DLY_W-1:0]  next_dly_w = i_delay_write ? i_delay_w_ms : dly_w;

    // Dividend is reused as the quotient register as it shifts out
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dly_e    <= '0;
            dly_w    <= '0;
            dvd_e    <= '0;
            dvd_w    <= '0;
            rem_e    <= '0;
            rem_w    <= '0;
            div_left <= '0;
            busy     <= 1'b0;
        end else if (restart) begin
            dly_e    <= next_dly_e;
            dly_w    <= next_dly_w;
            dvd_e    <= LEN_W'(next_dly_e) * LEN_W'(next_rate); // RULE9
            dvd_w    <= LEN_W'(next_dly_w) * LEN_W'(next_rate); // RULE9
            rem_e    <= '0;
            rem_w    <= '0;
            div_left <= 6'(LEN_W);
            busy     <= 1'b1; // RULE13
        end else if (busy) begin
            dvd_e    <= {dvd_e[LEN_W-2:0], step_e[11] || step_e != {rem_e, dvd_e[LEN_W-1]}};
            dvd_w    <= {dvd_w[LEN_W-2:0], step_w[11] || step_w != {rem_w, dvd_w[LEN_W-1]}};
            rem_e    <= step_e[10:0];
            rem_w    <= step_w[10:0];
            div_left <= div_left - 6'h01;
            busy     <= (div_left != 6'h01);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_len_e <= '0;
            o_len_w <= '0;
        end else if (busy && div_left == 6'h01) begin
            o_len_e <= {dvd_e[LEN_W-2:0], step_e != {rem_e, dvd_e[LEN_W-1]}};
            o_len_w <= {dvd_w[LEN_W-2:0], step_w != {rem_w, dvd_w[LEN_W-1]}};
        end
    end

    assign o_buf_reset = busy; // RULE13

    // ---------------- Data path ----------------
    wire around = (i_path_mode != DRCM_PATH_NORMAL);
    wire fill   = i_fill_ones;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_gen_enable <= 1'b0;
            o_east_out   <= 1'b0;
            o_west_out   <= 1'b0;
        end else begin
            o_gen_enable <= !around; // RULE11
            // Bypass wins: the buffers are then unused, so no fill
            o_east_out   <= around ? i_east_line : (busy ? fill : i_east_delayed); // RULE11 RULE13
            o_west_out   <= around ? i_west_line : (busy ? fill : i_west_delayed); // RULE11 RULE13
        end
    end

    // ---------------- Parameter edit timeout ----------------
    drcm_panel_t panel;
    drcm_panel_t next_panel;
    logic [31:0] idle_cnt;
    wire         idle_done = (idle_cnt == 32'(TIMEOUT_CYC - 1));

    always_comb begin
        case (panel)
            DRCM_ST_MAIN: next_panel = i_panel_change ? DRCM_ST_EDIT : DRCM_ST_MAIN;
            DRCM_ST_EDIT: next_panel = (idle_done && !i_panel_activity)
                                       ? DRCM_ST_MAIN : DRCM_ST_EDIT; // RULE12
            default:      next_panel = DRCM_ST_MAIN;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            panel    <= DRCM_ST_MAIN;
            idle_cnt <= '0;
        end else begin
            panel    <= next_panel;
            idle_cnt <= (panel != DRCM_ST_EDIT || i_panel_activity) ? '0
                      : idle_cnt + 32'h00000001; // RULE12
        end
    end

    assign o_param_edit = (panel == DRCM_ST_EDIT);

    // ---------------- Checks ----------------
    property p_sync_load;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        i_iface_load && !i_iface_fixed |=> rate == RATE_SYNC_HZ;
    endproperty
    a_sync_load: assert property (p_sync_load) else $error("sync load rate wrong"); // RULE1

    property p_synth_range;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        o_synth_freq >= RATE_MIN_HZ && o_synth_freq <= RATE_MAX_HZ
        && (rate >= RATE_MIN_HZ && rate <= RATE_MAX_HZ -> o_synth_freq == rate);
    endproperty
    a_synth_range: assert property (p_synth_range) else $error("synth word wrong"); // RULE2

    property p_osc_pick;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        fixed_iface && rate == nominal && i_timing == DRCM_TIME_INTERNAL
        |-> o_net_src == DRCM_SRC_OSC;
    endproperty
    a_osc_pick: assert property (p_osc_pick) else $error("oscillator not chosen"); // RULE3

    property p_copy;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        i_copy_req && !i_iface_load |=> rate == $past(meas[i_copy_sel]);
    endproperty
    a_copy: assert property (p_copy) else $error("copy of measurement lost"); // RULE8

    property p_blink_quiet;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        mismatch[CH_E_RX] == 1'b0 |=> o_led_blink[CH_E_RX] == 1'b0;
    endproperty
    a_blink_quiet: assert property (p_blink_quiet) else $error("led blinks w/o fault"); // RULE6

    property p_rx_dead;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        i_timing == DRCM_TIME_INTERNAL && meas[CH_W_RX] == '0 |-> mismatch[CH_W_RX];
    endproperty
    a_rx_dead: assert property (p_rx_dead) else $error("dead rx not flagged"); // RULE7

    sequence s_change;
        $changed(rate);
    endsequence
    sequence s_fill_hold;
        o_buf_reset[*8];
    endsequence
    property p_recompute;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        s_change |-> s_fill_hold;
    endproperty
    a_recompute: assert property (p_recompute) else $error("no buffer reset on change"); // RULE13

    property p_bypass;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        i_path_mode == DRCM_PATH_BYPASS |=> !o_gen_enable && o_east_out == $past(i_east_line);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not routed"); // RULE11

    property p_timeout;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        o_param_edit && idle_done && !i_panel_activity |=> !o_param_edit;
    endproperty
    a_timeout: assert property (p_timeout) else $error("edit timeout missed"); // RULE12

    property p_len_done;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        $fell(busy) && !restart |-> o_len_e == LEN_W'(dly_e) * LEN_W'(rate) / LEN_W'(MS_PER_S);
    endproperty
    a_len_done: assert property (p_len_done) else $error("east length wrong"); // RULE9

endmodule

//--- test/drcm_clk_src.sv
// Connector clock source standing in for the line or terminal gear.
// Assumes 125 ns clocks that stand low while their enable is low.
`timescale 1ns/1ps
module drcm_clk_src (
    // Control
    input  wire logic [3:0] i_en,
    // Clocks
    output logic [3:0]      o_clk
);
    initial begin
        o_clk = 4'h0;
        #7;
        forever begin
            #62.5 o_clk = ~o_clk & i_en;
        end
    end
endmodule

//--- test/data_rate_clock_monitor_test.sv
// Self-checking bench for the data-rate and clock monitor.
// Assumes shortened gate, timeout and blink counts.
`timescale 1ns/1ps
module data_rate_clock_monitor_test;
    import drcm_pkg::*;
    logic              clk, rst_n, ld, fx, rw, cr, dw, fo, el, wl, ed, wd, pa, pc, br, ge, eo, wo, pe;
    logic [RATE_W-1:0] nom, rv, rate, syn, m0, m1, m2, m3;
    logic [DLY_W-1:0]  de, dwm;
    logic [LEN_W-1:0]  le, lw;
    logic [3:0]        led, en, ck, acc;
    logic [1:0]        cs;
    drcm_timing_t      tim;
    drcm_path_t        pm;
    drcm_src_t         src;
    int                fails, num_checks;
    drcm_clk_src u_src (.i_en(en), .o_clk(ck));
    drcm_monitor #(.GATE_CYC(40), .TIMEOUT_CYC(50), .BLINK_CYC(4)) DUT (
        .i_clk_sys(clk), .i_reset_n(rst_n), .i_clk_w_rx(ck[0]), .i_clk_w_tx(ck[1]),
        .i_clk_e_tx(ck[2]), .i_clk_e_rx(ck[3]), .i_iface_load(ld), .i_iface_fixed(fx),
        .i_iface_nominal(nom), .i_rate_write(rw), .i_rate_value(rv), .i_copy_req(cr),
        .i_copy_sel(cs), .i_timing(tim), .i_path_mode(pm), .i_delay_write(dw),
        .i_delay_e_ms(de), .i_delay_w_ms(dwm), .i_fill_ones(fo), .i_east_line(el),
        .i_west_line(wl), .i_east_delayed(ed), .i_west_delayed(wd), .i_panel_activity(pa),
        .i_panel_change(pc), .o_rate(rate), .o_synth_freq(syn), .o_net_src(src),
        .o_meas_w_rx(m0), .o_meas_w_tx(m1), .o_meas_e_tx(m2), .o_meas_e_rx(m3),
        .o_led_blink(led), .o_len_e(le), .o_len_w(lw), .o_buf_reset(br), .o_gen_enable(ge),
        .o_east_out(eo), .o_west_out(wo), .o_param_edit(pe));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string n, input logic [LEN_W-1:0] e, input logic [LEN_W-1:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s exp %0h got %0h", n, e, g);
        end
    endtask
    task automatic chk_rng(input string n, input logic [RATE_W-1:0] g);
        num_checks++;
        if ((g >= 28'h62c && g <= 28'h654) !== 1'b1) begin
            fails++;
            $display("[ERR] %s exp 62c..654 got %0h", n, g);
        end
    endtask
    task automatic wr(input logic [RATE_W-1:0] v);
        @(posedge clk);
        rv <= v;
        rw <= 1'b1;
        @(posedge clk);
        rw <= 1'b0;
        #1;
    endtask
    task automatic load;
        @(posedge clk);
        ld <= 1'b1;
        @(posedge clk);
        ld <= 1'b0;
        #1;
    endtask
    // Blink phase is short, so collect any lit bit over several phases
    task automatic leds;
        acc = 4'h0;
        repeat (16) begin
            cyc(1);
            acc = acc | led;
        end
    endtask
    task automatic t_rate;
        load;
        chk("rate", 28'h178f40, rate);
        chk("src", DRCM_SRC_OSC, src);
        wr(28'h178f4a);
        chk("src", DRCM_SRC_SYNTH, src);
        wr(28'h3938700);
        chk("synth", RATE_MAX_HZ, syn);
        wr(28'h32);
        chk("synth", RATE_MIN_HZ, syn);
        fx <= 1'b0;
        load;
        chk("rate", RATE_SYNC_HZ, rate);
        tim <= DRCM_TIME_LOOP;
        cyc(1);
        chk("src", DRCM_SRC_LOOP, src);
        tim <= DRCM_TIME_EXTERNAL;
        cyc(1);
        chk("src", DRCM_SRC_EXT, src);
        tim <= DRCM_TIME_INTERNAL;
    endtask
    task automatic t_buf;
        wr(28'h1f40);
        cyc(42);
        @(posedge clk);
        dw <= 1'b1;
        @(posedge clk);
        dw <= 1'b0;
        cyc(1);
        chk("busy", 1'b1, br);
        chk("fill", 1'b1, eo);
        chk("fill_w", 1'b1, wo);
        cyc(41);
        chk("busy", 1'b0, br);
        chk("len_e", 42'h50, le);
        chk("len_w", 42'h18, lw);
        cyc(2);
        chk("data", 1'b0, eo);
    endtask
    task automatic t_path;
        el <= 1'b1;
        wl <= 1'b1;
        pm <= DRCM_PATH_BYPASS;
        cyc(2);
        chk("gen", 1'b0, ge);
        chk("east", 1'b1, eo);
        chk("west", 1'b1, wo);
        pm <= DRCM_PATH_OUT_LOOP;
        cyc(2);
        chk("gen", 1'b0, ge);
        pm <= DRCM_PATH_NORMAL;
        cyc(2);
        chk("gen", 1'b1, ge);
    endtask
    task automatic t_meas;
        wr(28'h640);
        cyc(1000);
        chk_rng("w_rx", m0);
        chk_rng("w_tx", m1);
        chk_rng("e_tx", m2);
        chk_rng("e_rx", m3);
        leds;
        chk("led", 4'h0, acc);
        en <= 4'h7;
        cyc(1000);
        leds;
        chk("led", 4'h8, acc);
        wr(28'h6a4);
        cyc(4);
        leds;
        chk("led", 4'hf, acc);
        @(posedge clk);
        cr <= 1'b1;
        @(posedge clk);
        cr <= 1'b0;
        #1;
        chk_rng("copy", rate);
    endtask
    task automatic t_panel;
        @(posedge clk);
        pc <= 1'b1;
        @(posedge clk);
        pc <= 1'b0;
        #1;
        chk("edit", 1'b1, pe);
        cyc(45);
        chk("edit", 1'b1, pe);
        cyc(10);
        chk("edit", 1'b0, pe);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #250000;
        fails++;
        test_done;
    end
    initial begin
        {rst_n, ld, rw, cr, dw, fo, el, wl, ed, wd, pa, pc, cs, de, dwm} = '0;
        {fx, fo, de, dwm, en} = {1'b1, 1'b1, 14'ha, 14'h3, 4'hf};
        nom = 28'h178f40;
        rv = '0;
        tim = DRCM_TIME_INTERNAL;
        pm = DRCM_PATH_NORMAL;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_rate;
        t_buf;
        t_path;
        t_meas;
        t_panel;
        test_done;
    end
endmodule
